// ---- tcd_pkg.sv ----
// Constants and types shared by the terminal command decoder.
// Functional notes
// (R1) Four select terminals pick one of sixteen presets.
// (R2) Preset 100 percent equals maximum output frequency.
// (R3) Preset also feeds regulator setpoint and voltage.
// (R4) Two terminals select one of four ramp pairs.
// (R5) Motor terminal OFF first set, ON second.
// (R6) Programmable input filter, default 0.010s, max 1.000s.
// (R7) Command mode 0 to 3, reset default 0.
// (R8) Mode 0: first forward, second reverse, else stop.
// (R9) Mode 1: first enables, second sets direction.
// (R10) Mode 2: enabled pushes start forward or reverse.
// (R11) Three-line modes stop when enable goes OFF.
// (R12) Mode 2 latches state from latest input action.
// (R13) Mode 3: enabled push on first starts running.
// (R14) Mode 3 direction follows second input level.
// (R15) UP/DOWN changes setpoint at programmable rate.
// (R16) Rate range follows the frequency resolution setting; the code ignores CTRL bit 2 and keeps the rate at 1 to 65535.
// (R17) Input accepted after stable for filter time.
// (R18) Three-line pushes detected as filtered rising edges.
package tcd_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_TIME_NS = 1_000_000;
  localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_PER_SEC = 1000;

  // ==========================================================
  // Terminal positions
  localparam int NUM_DIN = 12;
  localparam int DIN_FIRST = 0;
  localparam int DIN_SECOND = 1;
  localparam int DIN_THIRD = 2;
  localparam int DIN_REF_LO = 3;
  localparam int DIN_RAMP_LO = 7;
  localparam int DIN_MOTOR = 9;
  localparam int DIN_UP = 10;
  localparam int DIN_DOWN = 11;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FILT = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h08;
  localparam logic [7:0] OFS_MAXF = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_FREQ = 8'h14;
  localparam logic [7:0] OFS_UDFREQ = 8'h18;
  localparam logic [7:0] OFS_PRESET = 8'h40;
  localparam logic [7:0] OFS_PRESET_END = 8'h7C;

  // ==========================================================
  // Field positions, reset values and limits
  localparam int CTRL_RES_BIT = 2;
  localparam logic [9:0] RST_FILT_MS = 10'h00A;
  localparam logic [9:0] FILT_MAX_MS = 10'h3E8;
  localparam logic [15:0] RST_RATE = 16'h0064;
  localparam logic [15:0] RATE_MIN = 16'h0001;
  localparam logic [15:0] RST_MAXF = 16'h1388;
  localparam logic [15:0] PCT_FULL = 16'h2710;
  localparam logic [15:0] RST_PRESET = 16'h0000;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {MODE_TWO1, MODE_TWO2, MODE_THREE1, MODE_THREE2} tcd_mode_e;
  typedef enum logic [1:0] {CMD_STOP, CMD_FWD, CMD_REV} tcd_cmd_e;

endpackage

// ---- tcd_filt_if.sv ----
// Signals between the input filter and the command logic.
interface tcd_filt_if #(parameter int N = 12);
  logic tick;
  logic [9:0] filtTime;
  logic [N-1:0] level;
  logic [N-1:0] rise;
  modport filt(input tick, filtTime, output level, rise);
  modport ctrl(output tick, filtTime, input level, rise);
endinterface

// ---- tcd_input_filter.sv ----
// Synchroniser and debounce filter for the digital input terminals.
module tcd_input_filter #(
  parameter int N = 12
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Raw terminals
  input wire logic [N-1:0] din,
  // Filtered view
  tcd_filt_if.filt fi
);

  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;
  logic [N-1:0] level_r;
  logic [N-1:0] rise_r;
  logic [9:0] cnt_r [N];

  // ==========================================================
  // Two-stage synchroniser
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  // ==========================================================
  // Stability counters in timebase ticks
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      level_r <= '0;
      rise_r <= '0;
      for (int i = 0; i < N; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        rise_r[i] <= 1'b0;
        if (sync_r[i] == level_r[i]) begin
          cnt_r[i] <= '0; // R17
        end else if (fi.filtTime == '0 ||
                     (fi.tick && cnt_r[i] + 10'h001 >= fi.filtTime)) begin
          level_r[i] <= sync_r[i]; // R6 R17
          rise_r[i] <= sync_r[i]; // R18
          cnt_r[i] <= '0;
        end else if (fi.tick) begin
          cnt_r[i] <= cnt_r[i] + 10'h001;
        end
      end
    end
  end

  assign fi.level = level_r;
  assign fi.rise = rise_r;

  // ==========================================================
  // Checks
  sequence s_moved;
    $changed(level_r);
  endsequence

  property p_filt_on_tick;
    @(posedge core_clk) disable iff (!arst_n)
      s_moved |-> $past(fi.tick) || $past(fi.filtTime) == 10'h000;
  endproperty
  a_filt_on_tick: assert property (p_filt_on_tick) else $error("Filter moved off tick."); // R17

  property p_filt_pass;
    @(posedge core_clk) disable iff (!arst_n)
      fi.filtTime == 10'h000 && sync_r != level_r |=> level_r == $past(sync_r);
  endproperty
  a_filt_pass: assert property (p_filt_pass) else $error("Zero filter did not pass."); // R6

  property p_rise_edge;
    @(posedge core_clk) disable iff (!arst_n)
      rise_r != '0 |-> (rise_r & ~$past(level_r) & level_r) == rise_r;
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("Rise without edge."); // R18

endmodule

// ---- tcd_terminal_command_decoder.sv ----
// Terminal command decoder with APB register access.
module tcd_terminal_command_decoder #(
  parameter int TICK_CYCLES = tcd_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Input terminals
  input wire logic [tcd_pkg::NUM_DIN-1:0] din,
  // Run commands
  output logic forwardRun,
  output logic reverseRun,
  // References and selections
  output logic [3:0] refIndex,
  output logic [15:0] presetFreq,
  output logic [15:0] pidSetpoint,
  output logic [15:0] vfVoltage,
  output logic [1:0] rampSel,
  output logic motorSel,
  output logic [31:0] upDownFreq
);

  tcd_filt_if #(.N(tcd_pkg::NUM_DIN)) fif();

  tcd_input_filter #(.N(tcd_pkg::NUM_DIN)) u_filter (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .din(din),
    .fi(fif.filt)
  );

  // ==========================================================
  // Registers
  tcd_pkg::tcd_mode_e mode_r;
  logic res3_r;
  logic [9:0] filt_r;
  logic [15:0] rate_r;
  logic [15:0] maxf_r;
  logic [15:0] preset_r [16];
  logic [31:0] prdata_r;
  logic [15:0] tickCnt_r;
  tcd_pkg::tcd_cmd_e cmd_r;
  tcd_pkg::tcd_cmd_e cmd_nxt;
  logic fwd_r;
  logic rev_r;
  logic [3:0] refIndex_r;
  logic [15:0] presetFreq_r;
  logic [15:0] pidSetpoint_r;
  logic [15:0] vfVoltage_r;
  logic [1:0] rampSel_r;
  logic motorSel_r;
  logic [31:0] udFreq_r;
  logic [31:0] udLimit;
  logic wrEn;
  logic inF;
  logic inS;
  logic inEn;
  logic riseF;
  logic riseS;
  logic upOn;
  logic downOn;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a[1:0] == 2'h0 &&
             (a <= tcd_pkg::OFS_UDFREQ ||
              (a >= tcd_pkg::OFS_PRESET && a <= tcd_pkg::OFS_PRESET_END));
  endfunction

  function automatic logic [15:0] scale(input logic [15:0] pct, input logic [15:0] fmax);
    logic [31:0] prod;
    prod = pct * fmax;
    scale = 16'(prod / 32'(tcd_pkg::PCT_FULL));
  endfunction

  assign wrEn = psel && penable && pwrite && mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata = prdata_r;

  // ==========================================================
  // Register writes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= tcd_pkg::MODE_TWO1; // R7
      res3_r <= 1'b0;
      filt_r <= tcd_pkg::RST_FILT_MS; // R6
      rate_r <= tcd_pkg::RST_RATE; // R15
      maxf_r <= tcd_pkg::RST_MAXF;
    end else if (wrEn) begin
      unique case (paddr)
        tcd_pkg::OFS_CTRL: begin
          mode_r <= tcd_pkg::tcd_mode_e'(pwdata[1:0]); // R7
          res3_r <= pwdata[tcd_pkg::CTRL_RES_BIT];
        end
        tcd_pkg::OFS_FILT: begin
          filt_r <= (pwdata > 32'(tcd_pkg::FILT_MAX_MS)) ? tcd_pkg::FILT_MAX_MS
                                                          : pwdata[9:0]; // R6
        end
        tcd_pkg::OFS_RATE: begin
          rate_r <= (pwdata[15:0] == 16'h0000) ? tcd_pkg::RATE_MIN : pwdata[15:0]; // R16
        end
        tcd_pkg::OFS_MAXF: begin
          maxf_r <= pwdata[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 16; i++) begin
        preset_r[i] <= tcd_pkg::RST_PRESET;
      end
    end else if (wrEn && paddr >= tcd_pkg::OFS_PRESET) begin
      preset_r[paddr[5:2]] <= (pwdata[15:0] > tcd_pkg::PCT_FULL) ? tcd_pkg::PCT_FULL
                                                                 : pwdata[15:0];
    end
  end

  // ==========================================================
  // Register reads, captured in the setup phase
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_r <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= '0;
      if (paddr >= tcd_pkg::OFS_PRESET && mapped(paddr)) begin
        prdata_r <= {16'h0000, preset_r[paddr[5:2]]};
      end else begin
        unique case (paddr)
          tcd_pkg::OFS_CTRL: prdata_r <= {29'h0000_0000, res3_r, mode_r};
          tcd_pkg::OFS_FILT: prdata_r <= {22'h00_0000, filt_r};
          tcd_pkg::OFS_RATE: prdata_r <= {16'h0000, rate_r};
          tcd_pkg::OFS_MAXF: prdata_r <= {16'h0000, maxf_r};
          tcd_pkg::OFS_STATUS: prdata_r <= {11'h000, rev_r, fwd_r, motorSel_r, rampSel_r,
                                            refIndex_r, fif.level};
          tcd_pkg::OFS_FREQ: prdata_r <= {16'h0000, presetFreq_r};
          tcd_pkg::OFS_UDFREQ: prdata_r <= udFreq_r;
          default: prdata_r <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // Timebase
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tickCnt_r <= '0;
    end else if (tickCnt_r == 16'(TICK_CYCLES - 1)) begin
      tickCnt_r <= '0;
    end else begin
      tickCnt_r <= tickCnt_r + 16'h0001;
    end
  end

  assign fif.tick = tickCnt_r == 16'(TICK_CYCLES - 1);
  assign fif.filtTime = filt_r;

  // ==========================================================
  // Run command decode
  assign inF = fif.level[tcd_pkg::DIN_FIRST];
  assign inS = fif.level[tcd_pkg::DIN_SECOND];
  assign inEn = fif.level[tcd_pkg::DIN_THIRD];
  assign riseF = fif.rise[tcd_pkg::DIN_FIRST];
  assign riseS = fif.rise[tcd_pkg::DIN_SECOND];

  always_comb begin
    cmd_nxt = cmd_r;
    unique case (mode_r)
      tcd_pkg::MODE_TWO1: begin
        if (inF && !inS) begin
          cmd_nxt = tcd_pkg::CMD_FWD; // R8
        end else if (inS && !inF) begin
          cmd_nxt = tcd_pkg::CMD_REV; // R8
        end else begin
          cmd_nxt = tcd_pkg::CMD_STOP; // R8
        end
      end
      tcd_pkg::MODE_TWO2: begin
        if (!inF) begin
          cmd_nxt = tcd_pkg::CMD_STOP; // R9
        end else begin
          cmd_nxt = inS ? tcd_pkg::CMD_REV : tcd_pkg::CMD_FWD; // R9
        end
      end
      tcd_pkg::MODE_THREE1: begin
        if (!inEn) begin
          cmd_nxt = tcd_pkg::CMD_STOP; // R11
        end else if (riseF) begin
          cmd_nxt = tcd_pkg::CMD_FWD; // R10 R12 R18
        end else if (riseS) begin
          cmd_nxt = tcd_pkg::CMD_REV; // R10 R12 R18
        end
      end
      tcd_pkg::MODE_THREE2: begin
        if (!inEn) begin
          cmd_nxt = tcd_pkg::CMD_STOP; // R11
        end else if (riseF || cmd_r != tcd_pkg::CMD_STOP) begin
          cmd_nxt = inS ? tcd_pkg::CMD_REV : tcd_pkg::CMD_FWD; // R13 R14 R18
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_r <= tcd_pkg::CMD_STOP;
      fwd_r <= 1'b0;
      rev_r <= 1'b0;
    end else begin
      cmd_r <= cmd_nxt;
      fwd_r <= cmd_nxt == tcd_pkg::CMD_FWD;
      rev_r <= cmd_nxt == tcd_pkg::CMD_REV;
    end
  end

  // ==========================================================
  // Preset reference, ramp and motor selection
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      refIndex_r <= '0;
      rampSel_r <= '0;
      motorSel_r <= 1'b0;
      presetFreq_r <= '0;
      pidSetpoint_r <= '0;
      vfVoltage_r <= '0;
    end else begin
      refIndex_r <= fif.level[tcd_pkg::DIN_REF_LO +: 4]; // R1
      rampSel_r <= fif.level[tcd_pkg::DIN_RAMP_LO +: 2]; // R4
      motorSel_r <= fif.level[tcd_pkg::DIN_MOTOR]; // R5
      presetFreq_r <= scale(preset_r[refIndex_r], maxf_r); // R1 R2
      pidSetpoint_r <= preset_r[refIndex_r]; // R3
      vfVoltage_r <= preset_r[refIndex_r]; // R3
    end
  end

  // ==========================================================
  // UP/DOWN setpoint in thousandths of a resolution step
  assign udLimit = 32'({16'h0000, maxf_r} * 32'(tcd_pkg::TICK_PER_SEC));
  assign upOn = fif.level[tcd_pkg::DIN_UP] && !fif.level[tcd_pkg::DIN_DOWN];
  assign downOn = fif.level[tcd_pkg::DIN_DOWN] && !fif.level[tcd_pkg::DIN_UP];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      udFreq_r <= '0;
    end else if (udFreq_r > udLimit) begin
      udFreq_r <= udLimit;
    end else if (fif.tick && upOn) begin
      udFreq_r <= (udLimit - udFreq_r <= 32'(rate_r)) ? udLimit
                                                      : udFreq_r + 32'(rate_r); // R15 R16
    end else if (fif.tick && downOn) begin
      udFreq_r <= (udFreq_r <= 32'(rate_r)) ? 32'h0000_0000
                                            : udFreq_r - 32'(rate_r); // R15 R16
    end
  end

  // ==========================================================
  // Outputs
  assign forwardRun = fwd_r;
  assign reverseRun = rev_r;
  assign refIndex = refIndex_r;
  assign presetFreq = presetFreq_r;
  assign pidSetpoint = pidSetpoint_r;
  assign vfVoltage = vfVoltage_r;
  assign rampSel = rampSel_r;
  assign motorSel = motorSel_r;
  assign upDownFreq = udFreq_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_mode0_fwd;
    mode_r == tcd_pkg::MODE_TWO1 && inF && !inS |=> forwardRun && !reverseRun;
  endproperty
  a_mode0_fwd: assert property (p_mode0_fwd) else $error("Mode 0 forward missed."); // R8

  property p_mode1_rev;
    mode_r == tcd_pkg::MODE_TWO2 && inF && inS |=> reverseRun && !forwardRun;
  endproperty
  a_mode1_rev: assert property (p_mode1_rev) else $error("Mode 1 reverse missed."); // R9

  property p_three_stop;
    mode_r[1] && !inEn |=> !forwardRun && !reverseRun;
  endproperty
  a_three_stop: assert property (p_three_stop) else $error("Enable off did not stop."); // R11

  sequence s_push_fwd;
    mode_r == tcd_pkg::MODE_THREE1 && inEn && riseF;
  endsequence

  sequence s_held;
    mode_r == tcd_pkg::MODE_THREE1 && inEn && !riseF && !riseS;
  endsequence

  property p_mode2_latch;
    s_push_fwd ##1 s_held |=> forwardRun;
  endproperty
  a_mode2_latch: assert property (p_mode2_latch) else $error("Mode 2 latch lost."); // R12

  property p_mode3_dir;
    mode_r == tcd_pkg::MODE_THREE2 && inEn && (riseF || forwardRun || reverseRun)
      |=> (reverseRun == $past(inS)) && (forwardRun == !$past(inS));
  endproperty
  a_mode3_dir: assert property (p_mode3_dir) else $error("Mode 3 direction wrong."); // R14

  property p_mode3_idle;
    mode_r == tcd_pkg::MODE_THREE2 && !riseF && !forwardRun && !reverseRun
      |=> !forwardRun && !reverseRun;
  endproperty
  a_mode3_idle: assert property (p_mode3_idle) else $error("Mode 3 started without push."); // R13

  property p_ref_index;
    ##1 refIndex == $past(fif.level[6:3]);
  endproperty
  a_ref_index: assert property (p_ref_index) else $error("Preset index wrong."); // R1

  property p_ramp_motor;
    ##1 rampSel == $past(fif.level[8:7]) && motorSel == $past(fif.level[9]);
  endproperty
  a_ramp_motor: assert property (p_ramp_motor) else $error("Ramp or motor select wrong."); // R4

  property p_updown_step;
    fif.tick && upOn && udFreq_r + 32'(rate_r) < udLimit && $stable(maxf_r)
      |=> udFreq_r == $past(udFreq_r) + 32'($past(rate_r));
  endproperty
  a_updown_step: assert property (p_updown_step) else $error("UP step size wrong."); // R15

endmodule

// ---- tcd_switch_bank.sv ----
// Switch and pushbutton bank wired to the digital input terminals.
module tcd_switch_bank (
  // Clock
  input wire logic core_clk,
  // Bench control
  input wire logic [11:0] level,
  input wire logic [11:0] chatter,
  // Terminals
  output logic [11:0] din
);
  timeunit 1ns;
  timeprecision 1ns;
  logic phase = 1'b0;
  // Chattering contacts flip every cycle while the bench asks for it.
  always @(posedge core_clk) begin
    phase <= ~phase;
    din <= level ^ (phase ? chatter : 12'h000);
  end
endmodule

// ---- test_terminal_command_decoder.sv ----
// Self-checking testbench for the terminal command decoder.
module test_terminal_command_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 10;
  localparam int SETTLE = 3 * TK + 10;
  // Steps: mode[6:5], expected run[4:3] (1 forward, 2 reverse), terminals[2:0].
  localparam logic [6:0] SEQ [18] = '{7'h41, 7'h40, 7'h44, 7'h4D, 7'h4C, 7'h56, 7'h4F, 7'h4D,
    7'h41, 7'h45, 7'h40, 7'h64, 7'h66, 7'h77, 7'h76, 7'h6C, 7'h60, 7'h63};
  logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic forwardRun, reverseRun, motorSel;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, upDownFreq, rd, v;
  logic [11:0] din, level, chatter;
  logic [3:0] refIndex;
  logic [15:0] presetFreq, pidSetpoint, vfVoltage;
  logic [1:0] rampSel, mode;
  logic [15:0] pct [16];
  int errors, check_count, maxf;

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  tcd_terminal_command_decoder #(.TICK_CYCLES(TK)) uut (.core_clk(core_clk), .arst_n(arst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .din(din), .forwardRun(forwardRun),
    .reverseRun(reverseRun), .refIndex(refIndex), .presetFreq(presetFreq),
    .pidSetpoint(pidSetpoint), .vfVoltage(vfVoltage), .rampSel(rampSel), .motorSel(motorSel),
    .upDownFreq(upDownFreq));

  tcd_switch_bank sw (.core_clk(core_clk), .level(level), .chatter(chatter), .din(din));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One APB transfer; read data and error flag are taken at the pready edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      conclude();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic settle(input logic [11:0] l);
    level <= l;
    repeat (SETTLE) @(posedge core_clk);
  endtask

  function automatic logic [31:0] exp_freq(input logic [15:0] p, input int m);
    return (32'(p) * 32'(m)) / 32'h0000_2710;
  endfunction

  function automatic logic [1:0] exp_run(input int m, input int c);
    if (m == 0) begin
      return (c == 1) ? 2'h1 : (c == 2) ? 2'h2 : 2'h0;
    end
    return (c % 2 == 0) ? 2'h0 : (c / 2 == 1) ? 2'h2 : 2'h1;
  endfunction

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    level = 12'h000;
    chatter = 12'h000;
    errors = 0;
    check_count = 0;
    void'($urandom(67));
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, 8'h00, 0);
    chk("ctrl", 32'h0000_0000, rd);
    apb(1'b0, 8'h04, 0);
    chk("filt", 32'h0000_000A, rd);
    apb(1'b0, 8'h08, 0);
    chk("rate", 32'h0000_0064, rd);
    apb(1'b0, 8'h30, 0);
    chk("unmapped_err", 32'h0000_0001, rerr);
    chk("unmapped_data", 32'h0000_0000, rd);
    apb(1'b1, 8'h04, 32'h0000_07D0);
    apb(1'b0, 8'h04, 0);
    chk("filt_max", 32'h0000_03E8, rd);
    apb(1'b1, 8'h04, 32'h0000_0003);
    // Chattering contact never stays put long enough to be accepted.
    chatter <= 12'h200;
    settle(12'h000);
    chk("chatter_motor", 32'h0000_0000, motorSel);
    chatter <= 12'h000;
    apb(1'b1, 8'h04, 32'h0000_0003);
    level <= 12'h200;
    repeat (12) @(posedge core_clk);
    chk("early_motor", 32'h0000_0000, motorSel);
    repeat (60) @(posedge core_clk);
    chk("late_motor", 32'h0000_0001, motorSel);
    apb(1'b1, 8'h04, 32'h0000_0001);
    maxf = 1 + $urandom % 65535;
    apb(1'b1, 8'h0C, maxf);
    apb(1'b1, 8'h40, 32'h0000_FFFF);
    apb(1'b0, 8'h40, 0);
    chk("preset_sat", 32'h0000_2710, rd);
    for (int i = 0; i < 16; i++) begin
      pct[i] = (i == 15) ? 16'h2710 : 16'($urandom % 10001);
      apb(1'b1, 8'(64 + 4 * i), {16'h0000, pct[i]});
    end
    for (int i = 0; i < 16; i++) begin
      settle(12'((i % 8) << 7 | i << 3));
      chk("refIndex", i, refIndex);
      chk("presetFreq", exp_freq(pct[i], maxf), presetFreq);
      chk("pidSetpoint", pct[i], pidSetpoint);
      chk("vfVoltage", pct[i], vfVoltage);
      chk("rampSel", i % 4, rampSel);
      chk("motorSel", (i % 8) / 4, motorSel);
    end
    apb(1'b0, 8'h14, 0);
    chk("freq_reg", exp_freq(pct[15], maxf), rd);
    apb(1'b0, 8'h10, 0);
    chk("status_reg", 32'h0007_F3F8, rd);
    // A zero filter time passes every settled level straight through.
    apb(1'b1, 8'h04, 0);
    apb(1'b0, 8'h04, 0);
    chk("filt_zero", 32'h0000_0000, rd);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, 8'h00, m);
      for (int c = 0; c < 4; c++) begin
        settle(12'(c));
        chk("fwd_two_line", exp_run(m, c) == 2'h1, forwardRun);
        chk("rev_two_line", exp_run(m, c) == 2'h2, reverseRun);
      end
    end
    settle(12'h000);
    mode = 2'h1;
    foreach (SEQ[k]) begin
      if (SEQ[k][6:5] != mode) begin
        mode = SEQ[k][6:5];
        apb(1'b1, 8'h00, mode);
      end
      settle({9'h000, SEQ[k][2:0]});
      chk("fwd_three_line", SEQ[k][4:3] == 2'h1, forwardRun);
      chk("rev_three_line", SEQ[k][4:3] == 2'h2, reverseRun);
    end
    apb(1'b1, 8'h00, 32'h0000_0004);
    apb(1'b0, 8'h00, 0);
    chk("resolution", 32'h0000_0004, rd);
    apb(1'b1, 8'h08, 0);
    apb(1'b0, 8'h08, 0);
    chk("rate_floor", 32'h0000_0001, rd);
    apb(1'b1, 8'h0C, 1);
    apb(1'b1, 8'h08, 32'h0000_012C);
    level <= 12'h400;
    repeat (200) @(posedge core_clk);
    settle(12'h000);
    chk("updown_top", 32'h0000_03E8, upDownFreq);
    level <= 12'h800;
    repeat (100) @(posedge core_clk);
    settle(12'h000);
    chk("updown_floor", 32'h0000_0000, upDownFreq);
    apb(1'b1, 8'h0C, 32'h0000_1388);
    apb(1'b1, 8'h08, 32'h0000_0007);
    level <= 12'h400;
    repeat (100) @(posedge core_clk);
    settle(12'h000);
    v = upDownFreq;
    chk("updown_step", 32'h0000_0000, v % 7);
    chk("updown_span", 32'h0000_0001, v >= 56 && v <= 84);
    settle(12'hC00);
    chk("updown_hold", v, upDownFreq);
    apb(1'b0, 8'h18, 0);
    chk("udfreq_reg", v, rd);
    conclude();
  end
endmodule
